/* hw/mprs_defines.vh */
// constants for the module power-off and reset sequencer
`ifndef MPRS_DEFINES_VH
`define MPRS_DEFINES_VH
`define MPRS_CLK_HZ        40000000
`define MPRS_CYC_PER_MS    (`MPRS_CLK_HZ / 1000)
`define MPRS_BOOT_MS       50
`define MPRS_REFREQ_MS     99
`define MPRS_RSTPU_MS      390
`define MPRS_CNT_W         32
`define MPRS_MS_W          12
`define MPRS_ST_W          5
`define MPRS_ST_OFF        5'h01
`define MPRS_ST_BOOT       5'h02
`define MPRS_ST_RUN        5'h04
`define MPRS_ST_SHUT       5'h08
`define MPRS_ST_IDLE       5'h10
`endif

/* hw/mprs_sequencer.v */
// device-side power-off, reset and boot sequencing logic of the modem module
`timescale 1ns/10ps
`include "mprs_defines.vh"
// Overview of operation
// - power control low or floating turns off
// - off command, shutdown tasks, then ok answer
// - reset input low resets device immediately
// - reset discards data, drivers and network link
// - warm reset keeps device power on
// - request reference clock within Ton minus Ton2
// - reset input pulled up within 390 ms
// - usb mode skips pcie link steps
// - power control high turns on, low off
module mprs_sequencer #(
  parameter BOOT_MS   = `MPRS_BOOT_MS,
  parameter REFREQ_MS = `MPRS_REFREQ_MS,
  parameter RSTPU_MS  = `MPRS_RSTPU_MS,
  parameter CYC_MS    = `MPRS_CYC_PER_MS
) (
  input  wire SYS_CLK_I,
  input  wire RSTN_I,
  input  wire CLK_EN_I,
  input  wire PWR_ON_I,
  input  wire PWR_ON_VALID_I,
  input  wire MOD_RSTN_I,
  input  wire USB_MODE_I,
  input  wire FUNC_OFF_REQ_I,
  input  wire SHUT_DONE_I,
  output wire PWR_EN_O,
  output wire CORE_RSTN_O,
  output wire CLEAR_STATE_O,
  output wire FUNC_OFF_OK_O,
  output wire REFCLK_REQ_O,
  output wire RST_PU_EN_O,
  output wire RUNNING_O
);
  // one-hot state codes
  localparam [`MPRS_ST_W-1:0]  ST_OFF    = `MPRS_ST_OFF;
  localparam [`MPRS_ST_W-1:0]  ST_BOOT   = `MPRS_ST_BOOT;
  localparam [`MPRS_ST_W-1:0]  ST_RUN    = `MPRS_ST_RUN;
  localparam [`MPRS_ST_W-1:0]  ST_SHUT   = `MPRS_ST_SHUT;
  localparam [`MPRS_ST_W-1:0]  ST_IDLE   = `MPRS_ST_IDLE;

  // counter end points, sized to the counters they are compared with
  localparam [`MPRS_CNT_W-1:0] CYC_LAST  = CYC_MS - 1;
  localparam [`MPRS_MS_W-1:0]  BOOT_LAST = BOOT_MS - 1;
  localparam [`MPRS_MS_W-1:0]  REQ_LAST  = REFREQ_MS - 1;
  localparam [`MPRS_MS_W-1:0]  PU_LIMIT  = RSTPU_MS;
  localparam [`MPRS_MS_W-1:0]  MS_MAX    = {`MPRS_MS_W{1'b1}};
  localparam [`MPRS_CNT_W-1:0] CYC_ZERO  = {`MPRS_CNT_W{1'b0}};
  localparam [`MPRS_MS_W-1:0]  MS_ZERO   = {`MPRS_MS_W{1'b0}};

  reg  [`MPRS_ST_W-1:0]  state_q;
  reg  [`MPRS_ST_W-1:0]  state_d;
  reg  [`MPRS_CNT_W-1:0] cyc_q;
  reg  [`MPRS_CNT_W-1:0] cyc_d;
  reg  [`MPRS_MS_W-1:0]  ms_q;
  reg  [`MPRS_MS_W-1:0]  ms_d;
  reg                    pwr_q;
  reg                    pwr_d;
  reg                    core_q;
  reg                    core_d;
  reg                    ok_q;
  reg                    ok_d;
  reg                    clk_req_q;
  reg                    clk_req_d;
  reg                    pu_q;
  reg                    pu_d;
  reg                    clr_q;
  reg                    clr_d;
  wire                   pwr_req;
  wire                   ms_tick;
  wire                   in_boot;
  wire                   st_change;
  wire                   boot_next;
  wire                   off_next;
  wire                   live_next;

  // a floating power control pin counts as low, so the device never boots from noise
  assign pwr_req   = PWR_ON_I & PWR_ON_VALID_I;
  assign ms_tick   = (cyc_q == CYC_LAST);
  assign in_boot   = (state_q == ST_BOOT);
  assign st_change = (state_d != state_q);
  assign boot_next = (state_d == ST_BOOT);
  assign off_next  = (state_d == ST_OFF);
  assign live_next = (state_d == ST_RUN) | (state_d == ST_SHUT) | (state_d == ST_IDLE);

  // power and handshake state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (pwr_req) begin
          state_d = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (!pwr_req) begin
          state_d = ST_OFF;
        end else if (ms_tick && ms_q == BOOT_LAST) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!pwr_req) begin
          state_d = ST_OFF;
        end else if (FUNC_OFF_REQ_I) begin
          state_d = ST_SHUT;
        end
      end
      ST_SHUT: begin
        if (!pwr_req) begin
          state_d = ST_OFF;
        end else if (SHUT_DONE_I) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // only a power-off is expected after the answer; the core stays as it is
        if (!pwr_req) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // cycle counter runs only while booting and restarts at each millisecond
  always @* begin
    if (st_change || !in_boot || ms_tick) begin
      cyc_d = CYC_ZERO;
    end else begin
      cyc_d = cyc_q + 1'b1;
    end
  end

  // millisecond counter saturates so a stuck boot cannot wrap it
  always @* begin
    ms_d = ms_q;
    if (st_change) begin
      ms_d = MS_ZERO;
    end else if (in_boot && ms_tick && ms_q != MS_MAX) begin
      ms_d = ms_q + 1'b1;
    end
  end

  // next values of the registered outputs
  always @* begin
    // the reset input never touches the supply, so a warm reset is no power cycle
    pwr_d     = ~off_next;
    core_d    = live_next & MOD_RSTN_I;
    clr_d     = off_next | ~MOD_RSTN_I;
    ok_d      = (state_q == ST_SHUT) & (state_d == ST_IDLE);
    // link clock is not needed on usb; ask once boot reaches REFREQ_MS-1 ms, or at link release if boot ends sooner
    clk_req_d = ~USB_MODE_I & ~off_next &
                (~boot_next | (in_boot & (ms_q >= REQ_LAST)));
    pu_d      = ~off_next & (~boot_next | (ms_q < PU_LIMIT));
  end

  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= ST_OFF;
    end else if (CLK_EN_I) begin
      state_q <= state_d;
    end
  end

  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cyc_q <= CYC_ZERO;
    end else if (CLK_EN_I) begin
      cyc_q <= cyc_d;
    end
  end

  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ms_q <= MS_ZERO;
    end else if (CLK_EN_I) begin
      ms_q <= ms_d;
    end
  end

  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pwr_q <= 1'b0;
    end else if (CLK_EN_I) begin
      pwr_q <= pwr_d;
    end
  end

  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      core_q <= 1'b0;
    end else if (CLK_EN_I) begin
      core_q <= core_d;
    end
  end

  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      clr_q <= 1'b1;
    end else if (CLK_EN_I) begin
      clr_q <= clr_d;
    end
  end

  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ok_q <= 1'b0;
    end else if (CLK_EN_I) begin
      ok_q <= ok_d;
    end
  end

  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      clk_req_q <= 1'b0;
    end else if (CLK_EN_I) begin
      clk_req_q <= clk_req_d;
    end
  end

  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pu_q <= 1'b0;
    end else if (CLK_EN_I) begin
      pu_q <= pu_d;
    end
  end

  // reset input acts combinationally so entry into reset is immediate
  assign CORE_RSTN_O   = core_q & MOD_RSTN_I;
  assign CLEAR_STATE_O = clr_q | ~MOD_RSTN_I;
  assign PWR_EN_O      = pwr_q;
  assign FUNC_OFF_OK_O = ok_q;
  assign REFCLK_REQ_O  = clk_req_q;
  assign RST_PU_EN_O   = pu_q;
  assign RUNNING_O     = core_q & MOD_RSTN_I;
endmodule

/* verification/mprs_host_model.sv */
// host side: power control pin, push-pull reset line, off command
`timescale 1ns/10ps
module mprs_host_model (
  input  wire clk_i,
  output reg  pwr_on_o,
  output reg  pwr_vld_o,
  output wire mod_rstn_o,
  output reg  off_req_o
);
  reg rst_pd_q;
  assign mod_rstn_o = ~rst_pd_q; // driven high unless pulled down, not left to a pull-up
  initial begin
    {pwr_on_o, pwr_vld_o, rst_pd_q, off_req_o} = 4'h4;
  end
  task tick(input integer n); repeat (n) @(posedge clk_i); #1; endtask // own-clock delays
  task power_up; pwr_on_o = 1; endtask
  task drop; pwr_on_o = 0; endtask
  task send_off; off_req_o = 1; tick(1); off_req_o = 0; endtask
  task power_down(input float); tick(4); rst_pd_q = 1; tick(4);
    pwr_on_o = 0; pwr_vld_o = !float; tick(3600); rst_pd_q = 0; pwr_vld_o = 1; endtask
  task warm(input integer n); rst_pd_q = 1; tick(n); rst_pd_q = 0; endtask
endmodule

/* verification/mprs_sequencer_properties.sv */
// port assertions for the sequencer
`timescale 1ns/10ps
module mprs_sequencer_properties (
  input wire SYS_CLK_I, RSTN_I, CLK_EN_I, PWR_ON_I, PWR_ON_VALID_I, MOD_RSTN_I, USB_MODE_I, FUNC_OFF_REQ_I,
  input wire SHUT_DONE_I, PWR_EN_O, CORE_RSTN_O, CLEAR_STATE_O, FUNC_OFF_OK_O, REFCLK_REQ_O, RST_PU_EN_O, RUNNING_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  chk_off_on_low: assert property (CLK_EN_I && !(PWR_ON_I && PWR_ON_VALID_I) |=> !PWR_EN_O) else $error("power on");
  chk_rst_core: assert property (!MOD_RSTN_I |-> !CORE_RSTN_O && !RUNNING_O) else $error("core ran");
  chk_rst_clear: assert property (!MOD_RSTN_I |-> CLEAR_STATE_O) else $error("state kept");
  chk_warm_power: assert property (PWR_EN_O && !MOD_RSTN_I && PWR_ON_I && PWR_ON_VALID_I |=> PWR_EN_O) else $error("pw");
  chk_ok_pulse: assert property (FUNC_OFF_OK_O |=> !FUNC_OFF_OK_O) else $error("ok too long");
  chk_ok_cause: assert property ($rose(FUNC_OFF_OK_O) |-> $past(SHUT_DONE_I)) else $error("ok uncaused");
  chk_refclk_boot: assert property ($rose(REFCLK_REQ_O) |-> !CORE_RSTN_O) else $error("late request");
  chk_usb_noreq: assert property (USB_MODE_I |-> !REFCLK_REQ_O) else $error("usb request");
  // lower bound only: holds for the short bench boot and the full one
  chk_boot_time: assert property ($rose(CORE_RSTN_O) |-> $past(PWR_EN_O, 19)) else $error("boot short");
  cover property ($rose(FUNC_OFF_OK_O));
  cover property ($rose(CORE_RSTN_O));
  cover property (PWR_EN_O && !MOD_RSTN_I);
endmodule
bind mprs_sequencer mprs_sequencer_properties chk_u (.*);

/* verification/mprs_sequencer_tb.sv */
// self-checking bench for the power-off and reset sequencer
`timescale 1ns/10ps
module mprs_sequencer_tb;
  reg clk = 0, rstn = 0, usb = 0, done = 0, cen = 1;
  wire pon, pvld, mrst, offr, pen, crst, clr, ok, rreq, rpu, run;
  integer n_errors = 0, checked = 0, i, k;
  reg [2:0] rows [0:1];
  initial forever #12.5 clk = ~clk;
  mprs_host_model hm (.clk_i(clk), .pwr_on_o(pon), .pwr_vld_o(pvld), .mod_rstn_o(mrst), .off_req_o(offr));
  mprs_sequencer #(.CYC_MS(4), .BOOT_MS(5), .REFREQ_MS(2)) dut_u (.SYS_CLK_I(clk), .RSTN_I(rstn), .CLK_EN_I(cen),
    .PWR_ON_I(pon), .PWR_ON_VALID_I(pvld), .MOD_RSTN_I(mrst), .USB_MODE_I(usb), .FUNC_OFF_REQ_I(offr),
    .SHUT_DONE_I(done), .PWR_EN_O(pen), .CORE_RSTN_O(crst), .CLEAR_STATE_O(clr), .FUNC_OFF_OK_O(ok),
    .REFCLK_REQ_O(rreq), .RST_PU_EN_O(rpu), .RUNNING_O(run));
  task chk(input got, input exp); checked = checked + 1;
    if (got !== exp) begin n_errors = n_errors + 1; $display("MISMATCH %0t got %b", $time, got); end endtask
  task report_and_stop; $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish; endtask
  task boot; hm.power_up; hm.tick(1); chk(pen, 1'b1);
    hm.tick(30); chk(crst, 1'b1); chk(clr, 1'b0); endtask
  initial begin
    rows[0] = 3'h1; rows[1] = 3'h6; // {usb mode, pin floated, expected clock request}
    hm.tick(3); chk(pen, 1'b0); chk(clr, 1'b1); rstn = 1;
    for (i = 0; i < 2; i = i + 1) begin
      usb = rows[i][2]; boot; chk(rreq, rows[i][0]);
      chk(rpu, 1'b1); chk(run, 1'b1);
      hm.send_off; done = 1; k = 0;
      while (ok !== 1'b1 && k < 50) begin hm.tick(1); k = k + 1; end
      done = 0; chk(ok, 1'b1);
      if (k == 50) report_and_stop;
      hm.tick(1); chk(ok, 1'b0);
      hm.power_down(rows[i][1]); chk(pen, 1'b0);
      $display("row %0d ended", i);
    end
    boot; hm.warm(800); chk(pen, 1'b1);
    hm.tick(1); chk(crst, 1'b1); chk(clr, 1'b0);
    $display("warm reset ended");
    cen = 0; hm.drop; hm.tick(3); chk(pen, 1'b1);
    cen = 1; hm.tick(1); chk(pen, 1'b0); chk(clr, 1'b1);
    $display("freeze ended");
    usb = 0; boot; rstn = 0; hm.tick(1); chk(pen, 1'b0); chk(rreq, 1'b0); rstn = 1;
    hm.tick(2); chk(pen, 1'b1);
    $display("mid reset ended");
    report_and_stop;
  end
endmodule
